// ==== rtl/byte_mem.sv ====
// small byte buffer with a registered read port
`timescale 1ns/1ps
module byte_mem #(
	parameter int W = 8,
	parameter int D = 16,
	parameter int AW = $clog2(D)
) (
	// clock
	input  wire logic          clk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output      logic [W-1:0]  rdata_ff
);

	logic [W-1:0] mem [D];

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata_ff <= mem[raddr];
	end

endmodule // byte_mem

// ==== rtl/i2c_master_hold.sv ====
// two-channel two-wire bus master with bus hold, timeout and a wishbone register slave
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module i2c_master_hold #(
	parameter int NCH       = 2,
	parameter int DEPTH     = 16,
	parameter int MS_CYCLES = `MS_CYCLES
) (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           reset,
	// wishbone classic slave
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [31:0]    wb_adr_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic [31:0]    wb_dat_i,
	output      logic [31:0]    wb_dat_o,
	output      logic           wb_ack_o,
	// interrupt
	output      logic           irq,
	// open-drain bus pins, one per channel
	input  wire logic [NCH-1:0] scl_i,
	output      logic [NCH-1:0] scl_o,
	output      logic [NCH-1:0] scl_oe,
	input  wire logic [NCH-1:0] sda_i,
	output      logic [NCH-1:0] sda_o,
	output      logic [NCH-1:0] sda_oe
);

	i2cm_pkg::bus_s  bus_ff;
	i2cm_pkg::bus_s  nxt_bus;
	i2cm_pkg::chan_s ch_ff [NCH];
	logic [7:0]      rdata [NCH];
	logic            req;
	logic            wr;
	logic            mapped;
	logic            chn;
	logic [7:0]      off;
	logic            buf_hit;
	logic [31:0]     wmask;

	// master-only: there is no slave-mode logic anywhere in this block
	assign req     = wb_cyc_i & wb_stb_i;
	assign mapped  = (wb_adr_i[31:`CH_SEL_BIT+1] == 23'h000000)
		&& (int'(wb_adr_i[`CH_SEL_BIT]) < NCH);
	assign chn     = wb_adr_i[`CH_SEL_BIT];
	assign off     = {wb_adr_i[7:2], 2'h0};
	assign buf_hit = wb_adr_i[`BUF_BASE_BIT +: 2] == 2'h1;
	// writes commit at the edge that raises ack
	assign wr      = req & wb_we_i & bus_ff.phase & ~bus_ff.ack & mapped;
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	assign wb_dat_o = bus_ff.dat;
	assign wb_ack_o = bus_ff.ack;
	assign irq      = bus_ff.irq;

	function automatic logic [5:0] qtr_of(input logic [1:0] spd);
		logic [5:0] r;
		r = 6'(`QTR_100K - 1);
		if (spd == `SPD_400K)
		begin
			r = 6'(`QTR_400K - 1);
		end
		else if (spd == `SPD_1000K)
		begin
			r = 6'(`QTR_1000K - 1);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// channels
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gch
			i2cm_pkg::chan_s n;
			i2cm_pkg::chan_s c;
			logic            sel_me;
			logic            busy;
			logic            tick;
			logic            mem_we;
			logic [3:0]      mem_wa;
			logic [3:0]      mem_ra;
			logic [7:0]      mem_wd;
			logic [2:0]      irq_set;
			logic [31:0]     cmdw;

			assign c      = ch_ff[g];
			assign sel_me = wr && (int'(chn) == g);
			assign busy   = c.st != i2cm_pkg::ENG_IDLE;
			assign tick   = c.div == 6'h00;
			assign cmdw   = wb_dat_i & wmask;

			// bus owns the buffer only while the channel is idle
			assign mem_we = c.mem_we | (sel_me & buf_hit & ~busy & wb_sel_i[0]);
			assign mem_wa = c.mem_we ? c.mem_wa : wb_adr_i[5:2];
			assign mem_wd = c.mem_we ? c.mem_wd : wb_dat_i[7:0];
			assign mem_ra = busy ? c.idx[3:0] : wb_adr_i[5:2];

			byte_mem #(
				.W (8),
				.D (DEPTH)
			) u_buf (
				.clk      (clk),
				.we       (mem_we),
				.waddr    (mem_wa),
				.wdata    (mem_wd),
				.raddr    (mem_ra),
				.rdata_ff (rdata[g])
			);

			always_comb
			begin
				n         = c;
				irq_set   = 3'h0;
				n.mem_we  = 1'b0;
				n.scl_sync = {c.scl_sync[1:0], scl_i[g]};
				n.sda_sync = {c.sda_sync[1:0], sda_i[g]};
				if (c.scl_sync[1] == c.scl_sync[2])
				begin
					n.scl_filt = c.scl_sync[2];
				end
				if (c.sda_sync[1] == c.sda_sync[2])
				begin
					n.sda_filt = c.sda_sync[2];
				end

				// quarter-bit timing
				if (busy)
				begin
					n.div = tick ? qtr_of(c.speed) : c.div - 6'h01;
					if (tick)
					begin
						n.q = c.q + 2'h1;
					end
				end

				if (busy && c.st != i2cm_pkg::ENG_STOP && c.tmo != 16'h0000)
				begin
					if (c.mscyc == 24'(MS_CYCLES - 1))
					begin
						n.mscyc = 24'h000000;
						n.ms    = c.ms + 16'h0001;
					end
					else
					begin
						n.mscyc = c.mscyc + 24'h000001;
					end
				end

				if (busy && tick)
				begin
					unique case (c.st)
						i2cm_pkg::ENG_START:
						begin
							// same sequence gives a repeated start on a held bus
							unique case (c.q)
								2'h0: n.sda_oe = 1'b0;
								2'h1: n.scl_oe = 1'b0;
								2'h2: n.sda_oe = 1'b1;
								2'h3:
								begin
									n.scl_oe     = 1'b1;
									n.held       = 1'b0;
									n.shift      = {c.saddr, c.rd};
									n.bitn       = 4'h0;
									n.addr_phase = 1'b1;
									n.st         = i2cm_pkg::ENG_SEND;
								end
							endcase
						end
						i2cm_pkg::ENG_SEND:
						begin
							unique case (c.q)
								2'h0: n.sda_oe = (c.bitn == 4'h8) ? 1'b0 : ~c.shift[7];
								2'h1: n.scl_oe = 1'b0;
								2'h2: n.nack = (c.bitn == 4'h8) ? c.sda_filt : c.nack;
								2'h3:
								begin
									n.scl_oe = 1'b1;
									n.bitn   = c.bitn + 4'h1;
									n.shift  = {c.shift[6:0], 1'b0};
									if (c.bitn == 4'h8)
									begin
										n.bitn       = 4'h0;
										n.addr_phase = 1'b0;
										if (c.nack)
										begin
											irq_set[`IRQ_NACK] = 1'b1;
											n.st = i2cm_pkg::ENG_STOP;
										end
										else if (c.addr_phase && c.rd && c.len != 5'h00)
										begin
											n.st = i2cm_pkg::ENG_RECV;
										end
										// next byte in order, exactly len of them
										else if (!c.rd && c.idx != c.len)
										begin
											n.shift = rdata[g];
											n.idx   = c.idx + 5'h01;
										end
										else
										begin
											irq_set[`IRQ_DONE] = 1'b1;
											n.st   = (c.hold && c.open) ? i2cm_pkg::ENG_IDLE
												: i2cm_pkg::ENG_STOP;
											n.held = c.hold && c.open;
										end
									end
								end
							endcase
						end
						i2cm_pkg::ENG_RECV:
						begin
							unique case (c.q)
								// ack all but the last byte
								2'h0: n.sda_oe = (c.bitn == 4'h8) && (c.idx + 5'h01 != c.len);
								2'h1: n.scl_oe = 1'b0;
								2'h2:
								begin
									if (c.bitn != 4'h8)
									begin
										n.shift = {c.shift[6:0], c.sda_filt};
									end
								end
								2'h3:
								begin
									n.scl_oe = 1'b1;
									n.bitn   = c.bitn + 4'h1;
									if (c.bitn == 4'h7)
									begin
										n.mem_we = 1'b1;
										n.mem_wa = c.idx[3:0];
										n.mem_wd = c.shift;
									end
									if (c.bitn == 4'h8)
									begin
										n.bitn = 4'h0;
										n.idx  = c.idx + 5'h01;
										if (c.idx + 5'h01 == c.len)
										begin
											irq_set[`IRQ_DONE] = 1'b1;
											n.st   = (c.hold && c.open) ? i2cm_pkg::ENG_IDLE
												: i2cm_pkg::ENG_STOP;
											n.held = c.hold && c.open;
										end
									end
								end
							endcase
						end
						i2cm_pkg::ENG_STOP:
						begin
							unique case (c.q)
								2'h0:
								begin
									n.scl_oe = 1'b1;
									n.sda_oe = 1'b1;
								end
								2'h1: n.scl_oe = 1'b0;
								2'h2: n.sda_oe = 1'b0;
								2'h3:
								begin
									n.held = 1'b0;
									n.st   = i2cm_pkg::ENG_IDLE;
								end
							endcase
						end
						default: n.st = i2cm_pkg::ENG_IDLE;
					endcase
				end

				// abort releases the bus with a stop
				if (busy && c.st != i2cm_pkg::ENG_STOP && c.tmo != 16'h0000 && c.ms >= c.tmo)
				begin
					n.tmo_hit           = 1'b1;
					irq_set[`IRQ_TMO]   = 1'b1;
					n.st                = i2cm_pkg::ENG_STOP;
					n.q                 = 2'h0;
					n.div               = qtr_of(c.speed);
				end

				// register writes
				if (sel_me && !buf_hit)
				begin
					unique case (off)
						`REG_CTRL:
						begin
							if (wb_sel_i[0])
							begin
								n.open = wb_dat_i[`CTRL_OPEN];
								// only the three speeds are accepted
								if (wb_dat_i[`CTRL_SPD_LO +: 2] != 2'h3 && !busy)
								begin
									n.speed = wb_dat_i[`CTRL_SPD_LO +: 2];
								end
								// close on a held bus sends the stop first
								if (!wb_dat_i[`CTRL_OPEN] && c.held && !busy)
								begin
									n.st  = i2cm_pkg::ENG_STOP;
									n.q   = 2'h0;
									n.div = qtr_of(c.speed);
								end
							end
						end
						`REG_TMO: n.tmo = (c.tmo & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
						`REG_CMD:
						begin
							if (c.open && !busy && wb_sel_i[0])
							begin
								n.saddr   = cmdw[6:0];
								n.rd      = cmdw[`CMD_RD];
								n.hold    = cmdw[`CMD_HOLD];
								n.len     = cmdw[`CMD_LEN_LO +: 5];
								n.idx     = 5'h00;
								n.nack    = 1'b0;
								n.tmo_hit = 1'b0;
								n.ms      = 16'h0000;
								n.mscyc   = 24'h000000;
								n.q       = 2'h0;
								n.div     = qtr_of(c.speed);
								n.st      = i2cm_pkg::ENG_START;
							end
						end
						`REG_IRQ_CLR: n.irq_st = c.irq_st & ~wb_dat_i[2:0];
						`REG_IRQ_EN: n.irq_en = wb_sel_i[0] ? wb_dat_i[2:0] : c.irq_en;
						default: n.irq_en = c.irq_en;
					endcase
				end
				// a new event wins over a clear in the same cycle
				n.irq_st = n.irq_st | irq_set;
			end

			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					ch_ff[g] <= '{st: i2cm_pkg::ENG_IDLE, speed: `SPD_100K, tmo: `TMO_RESET,
						scl_sync: 3'h7, sda_sync: 3'h7, scl_filt: 1'b1, sda_filt: 1'b1,
						default: '0};
				end
				else
				begin
					ch_ff[g] <= n;
				end
			end

			// every channel is the same engine
			assign scl_o[g]  = 1'b0;
			assign sda_o[g]  = 1'b0;
			assign scl_oe[g] = ch_ff[g].scl_oe;
			assign sda_oe[g] = ch_ff[g].sda_oe;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// wishbone answer: ack two edges after the request is seen
	always_comb
	begin
		i2cm_pkg::chan_s r;
		logic            any;
		r       = ch_ff[0];
		any     = 1'b0;
		nxt_bus = bus_ff;
		if (NCH > 1 && chn)
		begin
			r = ch_ff[NCH-1];
		end
		nxt_bus.phase = bus_ff.ack ? 1'b0 : (req | bus_ff.phase);
		nxt_bus.ack   = req & bus_ff.phase & ~bus_ff.ack;
		if (req && bus_ff.phase && !bus_ff.ack)
		begin
			nxt_bus.dat = 32'h00000000;
			if (mapped && !wb_we_i)
			begin
				if (buf_hit)
				begin
					nxt_bus.dat = {24'h000000, rdata[chn]};
				end
				else
				begin
					unique case (off)
						`REG_CTRL: nxt_bus.dat = {29'h00000000, r.speed, r.open};
						`REG_TMO: nxt_bus.dat = {16'h0000, r.tmo};
						`REG_CMD: nxt_bus.dat = {11'h000, r.len, 7'h00, r.hold, r.rd, r.saddr};
						`REG_STAT: nxt_bus.dat = {27'h0000000, r.open, r.tmo_hit, r.nack, r.held,
							r.st != i2cm_pkg::ENG_IDLE};
						`REG_IRQ_ST: nxt_bus.dat = {29'h00000000, r.irq_st};
						`REG_IRQ_EN: nxt_bus.dat = {29'h00000000, r.irq_en};
						default: nxt_bus.dat = 32'h00000000;
					endcase
				end
			end
		end
		for (int i = 0; i < NCH; i++)
		begin
			any = any | (|(ch_ff[i].irq_st & ch_ff[i].irq_en));
		end
		nxt_bus.irq = any;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bus_ff <= '0;
		end
		else
		begin
			bus_ff <= nxt_bus;
		end
	end

endmodule // i2c_master_hold

// ==== rtl/i2cm_defs.svh ====
// register map, field positions, reset values and timing counts of the two-wire master
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

`define CLK_HZ        20000000
`define SCL_100K_HZ   100000
`define SCL_400K_HZ   400000
`define SCL_1000K_HZ  1000000
// quarter bit periods, rounded up so the bus never runs above its rate
`define QTR_100K      ((`CLK_HZ + 4 * `SCL_100K_HZ - 1) / (4 * `SCL_100K_HZ))
`define QTR_400K      ((`CLK_HZ + 4 * `SCL_400K_HZ - 1) / (4 * `SCL_400K_HZ))
`define QTR_1000K     ((`CLK_HZ + 4 * `SCL_1000K_HZ - 1) / (4 * `SCL_1000K_HZ))
`define TMO_UNIT_US   1000
`define MS_CYCLES     (`CLK_HZ / 1000000 * `TMO_UNIT_US)
`define TMO_MIN_MS    100

`define SPD_100K      2'h0
`define SPD_400K      2'h1
`define SPD_1000K     2'h2

`define REG_CTRL      8'h00
`define REG_TMO       8'h04
`define REG_CMD       8'h08
`define REG_STAT      8'h0c
`define REG_IRQ_ST    8'h10
`define REG_IRQ_CLR   8'h14
`define REG_IRQ_EN    8'h18
`define BUF_BASE_BIT  6
`define CH_SEL_BIT    8

`define CTRL_OPEN     0
`define CTRL_SPD_LO   1
`define CMD_RD        7
`define CMD_HOLD      8
`define CMD_LEN_LO    16

`define IRQ_DONE      0
`define IRQ_NACK      1
`define IRQ_TMO       2

`define TMO_RESET     16'h0000

`endif

// ==== rtl/i2cm_pkg.sv ====
// types shared by the two-wire master and its bus slave
package i2cm_pkg;

	typedef enum logic [2:0] {
		ENG_IDLE,
		ENG_START,
		ENG_SEND,
		ENG_RECV,
		ENG_STOP
	} eng_e;

	typedef struct packed {
		eng_e        st;
		logic [1:0]  q;
		logic [5:0]  div;
		logic [3:0]  bitn;
		logic [7:0]  shift;
		logic [4:0]  idx;
		logic [4:0]  len;
		logic [6:0]  saddr;
		logic        rd;
		logic        hold;
		logic        held;
		logic        addr_phase;
		logic        scl_oe;
		logic        sda_oe;
		logic        open;
		logic [1:0]  speed;
		logic [15:0] tmo;
		logic [15:0] ms;
		logic [23:0] mscyc;
		logic        nack;
		logic        tmo_hit;
		logic [2:0]  irq_st;
		logic [2:0]  irq_en;
		logic        mem_we;
		logic [3:0]  mem_wa;
		logic [7:0]  mem_wd;
		logic [2:0]  scl_sync;
		logic [2:0]  sda_sync;
		logic        scl_filt;
		logic        sda_filt;
	} chan_s;

	typedef struct packed {
		logic        phase;
		logic        ack;
		logic [31:0] dat;
		logic        irq;
	} bus_s;

endpackage

// ==== test/i2c_master_hold_assertions.sv ====
// concurrent checks on the register bus and bus pins of the two-wire master
`timescale 1ns/1ps
module i2c_master_hold_assertions #(
	parameter int NCH = 2
) (
	// clock and reset
	input wire logic           clk,
	input wire logic           reset,
	// wishbone
	input wire logic           wb_cyc_i,
	input wire logic           wb_stb_i,
	input wire logic           wb_we_i,
	input wire logic [31:0]    wb_adr_i,
	input wire logic [3:0]     wb_sel_i,
	input wire logic [31:0]    wb_dat_i,
	input wire logic [31:0]    wb_dat_o,
	input wire logic           wb_ack_o,
	input wire logic           irq,
	// bus pins
	input wire logic [NCH-1:0] scl_i,
	input wire logic [NCH-1:0] scl_o,
	input wire logic [NCH-1:0] scl_oe,
	input wire logic [NCH-1:0] sda_i,
	input wire logic [NCH-1:0] sda_o,
	input wire logic [NCH-1:0] sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic req;
	assign req = wb_cyc_i & wb_stb_i;
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
	property p_ack_lat; $rose(req) |-> ##1 !wb_ack_o ##1 wb_ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack not two cycles after request");
	property p_ack_req; wb_ack_o |-> req && $past(req, 2); endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without a held request");
	property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i[31:9] != 0 |-> wb_dat_o == 0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_od; scl_o == 0 && sda_o == 0; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_rst_pins; $past(reset) |-> scl_oe == 0 && sda_oe == 0; endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("bus pulled after reset");
	property p_rst_bus; $past(reset) |-> !wb_ack_o && !irq && wb_dat_o == 0; endproperty
	a_rst_bus: assert property (p_rst_bus) else $error("bus outputs set after reset");
	// start must be followed by clock low
	property p_start; $rose(sda_oe[0]) && !scl_oe[0] |=> ##[0:120] scl_oe[0]; endproperty
	a_start: assert property (p_start) else $error("start without clock low");
	c_write: cover property (wb_ack_o && wb_we_i);
	c_irq: cover property ($rose(irq));
	c_start: cover property ($rose(sda_oe[0]) && !scl_oe[0]);
endmodule // i2c_master_hold_assertions

bind i2c_master_hold i2c_master_hold_assertions #(.NCH(NCH)) u_chk (
	.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .irq(irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

// ==== test/i2c_master_with_bus_hold_tb_top.sv ====
// testbench: register traffic, modelled slaves and checks of the two-wire master
`timescale 1ns/1ps
`include "i2cm_defs.svh"
module i2c_master_with_bus_hold_tb_top;
	logic        clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, scl_d = 0;
	logic [22:0] hi = 0;
	logic [8:0]  adr = 0;
	logic [3:0]  sel = 0, msk = 4'hf;
	logic [31:0] dat = 0, rdat;
	wire  [31:0] dat_o;
	wire  [1:0]  scl_o, scl_oe, sda_o, sda_oe, s_oe, sda_w;
	wire         ack, irq;
	int          fails = 0, checks_done = 0, per = 0, cnt = 0;
	assign sda_w = ~sda_oe & ~s_oe;
	always #25 clk = ~clk;
	// clock period between pulls low
	always @(posedge clk)
	begin
		scl_d <= scl_oe[0];
		cnt <= scl_oe[0] && !scl_d ? 1 : cnt + 1;
		if (scl_oe[0] && !scl_d)
			per <= cnt;
	end
	i2c_master_hold #(.MS_CYCLES(20)) u_dut (
		.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i({hi, adr}), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .irq(irq), .scl_i(~scl_oe), .scl_o(scl_o), .scl_oe(scl_oe),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
	);
	i2c_slave_model u_s0 (.clk(clk), .scl(~scl_oe[0]), .sda(sda_w[0]), .sda_oe_ff(s_oe[0]));
	i2c_slave_model u_s1 (.clk(clk), .scl(~scl_oe[1]), .sda(sda_w[1]), .sda_oe_ff(s_oe[1]));
	function automatic logic [7:0] pat(input int i);
		return i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'(i * 37);
	endfunction
	task automatic test_done;
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wb(input logic w, input logic c, input logic [7:0] o, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= msk;
		adr <= {c, o};
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic c, input logic [7:0] o, input logic [31:0] e);
		wb(0, c, o, 32'h0);
		chk(rdat, e);
	endtask
	task automatic idle(input logic c);
		// no local limit: a stuck engine runs into the watchdog
		do
			wb(0, c, `REG_STAT, 32'h0);
		while (rdat[0] !== 1'b0);
	endtask
	task automatic cmd(input logic c, input logic [6:0] a, input logic r, h, input logic [4:0] n);
		wb(1, c, `REG_CMD, {11'h0, n, 7'h0, h, r, a});
		idle(c);
	endtask
	task automatic fill(input logic c, input int n, input int o);
		for (int i = 0; i < n; i++)
			wb(1, c, 8'(8'h40 + 4 * i), {24'h0, pat(i + o)});
	endtask
	initial
	begin
		#3000000;
		fails++;
		test_done();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 0;
		rchk(0, `REG_CTRL, 32'h0);
		rchk(0, `REG_TMO, {16'h0, `TMO_RESET});
		rchk(0, `REG_IRQ_EN, 32'h0);
		// unmapped write must be dropped
		hi <= 23'h1;
		wb(1, 0, `REG_CTRL, 32'h1);
		hi <= 23'h0;
		rchk(0, `REG_CTRL, 32'h0);
		for (int s = 0; s < 3; s++)
		begin
			wb(1, 0, `REG_CTRL, 32'(s * 2 + 1));
			cmd(0, 7'h50, 0, 0, 0);
			chk(32'(per), 32'(4 * (s == 0 ? `QTR_100K : s == 1 ? `QTR_400K : `QTR_1000K)));
		end
		rchk(0, `REG_STAT, 32'h10);
		// unmapped read of an open channel still gives zero
		hi <= 23'h1;
		rchk(0, `REG_STAT, 32'h0);
		hi <= 23'h0;
		rchk(1, `REG_STAT, 32'h0);
		wb(1, 0, `REG_CTRL, 32'h7);
		rchk(0, `REG_CTRL, 32'h5);
		fill(0, 3, 0);
		cmd(0, 7'h50, 0, 1, 3);
		rchk(0, `REG_STAT, 32'h12);
		chk({30'h0, u_s0.act_ff, scl_oe[0]}, 32'h3);
		for (int i = 0; i < 3; i++)
			chk(32'(u_s0.mem_ff[i]), 32'(pat(i)));
		fill(0, 3, 5);
		cmd(0, 7'h50, 1, 0, 3);
		for (int i = 0; i < 3; i++)
			rchk(0, 8'(8'h40 + 4 * i), 32'(pat(i)));
		chk(32'(u_s0.ptr_ff), 32'h3);
		rchk(0, `REG_STAT, 32'h10);
		cmd(0, 7'h50, 0, 1, 1);
		wb(1, 0, `REG_CTRL, 32'h4);
		idle(0);
		rchk(0, `REG_STAT, 32'h0);
		chk({30'h0, u_s0.act_ff, sda_w[0]}, 32'h1);
		wb(1, 0, `REG_CTRL, 32'h5);
		wb(1, 0, `REG_TMO, 32'd100);
		rchk(0, `REG_TMO, 32'd100);
		// byte lane 0 only: upper timeout byte kept
		msk <= 4'h1;
		wb(1, 0, `REG_TMO, 32'h0000ff00);
		msk <= 4'hf;
		rchk(0, `REG_TMO, 32'h0);
		wb(1, 0, `REG_IRQ_CLR, 32'h7);
		fill(0, 16, 0);
		cmd(0, 7'h50, 0, 0, 16);
		rchk(0, `REG_IRQ_ST, 32'h1);
		wb(1, 0, `REG_IRQ_EN, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wb(1, 0, `REG_IRQ_EN, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wb(1, 1, `REG_CTRL, 32'h5);
		fill(1, 2, 1);
		cmd(1, 7'h50, 0, 0, 2);
		chk(32'(u_s1.mem_ff[1]), 32'(pat(2)));
		fill(1, 1, 4);
		// single-byte destination reads one byte
		cmd(1, 7'h50, 1, 0, 1);
		rchk(1, 8'h40, 32'(pat(1)));
		cmd(1, 7'h51, 0, 0, 0);
		wb(0, 1, `REG_IRQ_ST, 32'h0);
		chk(rdat & 32'h2, 32'h2);
		// abort last: a slave cut mid-ack may hold the wire
		wb(1, 1, `REG_IRQ_CLR, 32'h7);
		wb(1, 1, `REG_TMO, 32'd100);
		fill(1, 16, 0);
		cmd(1, 7'h50, 0, 0, 16);
		wb(0, 1, `REG_IRQ_ST, 32'h0);
		chk(rdat & 32'h5, 32'h4);
		wb(0, 1, `REG_STAT, 32'h0);
		chk(rdat & 32'h19, 32'h18);
		test_done();
	end
endmodule // i2c_master_with_bus_hold_tb_top

// ==== test/i2c_slave_model.sv ====
// behavioural addressed slave on one two-wire bus, with a 16-byte memory
`timescale 1ns/1ps
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	// clock
	input  wire logic clk,
	// resolved wire levels
	input  wire logic scl,
	input  wire logic sda,
	// pulls sda low
	output logic      sda_oe_ff
);
	logic       scl_ff = 1, sda_ff = 1, act_ff = 0, rd_ff = 0, first_ff = 0;
	logic [3:0] bit_ff = 0, ptr_ff = 0;
	logic [7:0] sh_ff = 0, tx_ff = 0;
	logic [7:0] mem_ff [16];
	initial sda_oe_ff = 0;
	always @(posedge clk)
	begin
		scl_ff <= scl;
		sda_ff <= sda;
		if (scl && scl_ff && sda_ff && !sda)
		begin
			act_ff <= 1;
			first_ff <= 1;
			rd_ff <= 0;
			bit_ff <= 0;
			ptr_ff <= 0;
		end
		else if (scl && scl_ff && !sda_ff && sda)
			act_ff <= 0;
		else if (act_ff && scl && !scl_ff)
		begin
			bit_ff <= bit_ff + 1;
			sh_ff <= bit_ff < 8 ? {sh_ff[6:0], sda} : sh_ff;
			// a master nack ends the read
			if (bit_ff == 8 && rd_ff && sda)
				act_ff <= 0;
		end
		else if (act_ff && !scl && scl_ff)
		begin
			sda_oe_ff <= 0;
			if (bit_ff == 8 && first_ff)
			begin
				rd_ff <= sh_ff[0];
				act_ff <= sh_ff[7:1] == ADDR;
				sda_oe_ff <= sh_ff[7:1] == ADDR;
			end
			else if (bit_ff == 8 && !rd_ff)
			begin
				mem_ff[ptr_ff] <= sh_ff;
				ptr_ff <= ptr_ff + 1;
				sda_oe_ff <= 1;
			end
			else if (bit_ff == 9)
			begin
				bit_ff <= 0;
				first_ff <= 0;
				if (rd_ff)
				begin
					sda_oe_ff <= !mem_ff[ptr_ff][7];
					tx_ff <= mem_ff[ptr_ff] << 1;
					ptr_ff <= ptr_ff + 1;
				end
			end
			else if (bit_ff < 8 && rd_ff && !first_ff)
			begin
				sda_oe_ff <= !tx_ff[7];
				tx_ff <= tx_ff << 1;
			end
		end
	end
endmodule // i2c_slave_model
